// [ssfc_pkg.sv]
// Purpose: Shared constants and types for the serial software flow control
// Assumes: 16-bit register port, 8-bit characters
// Notes: Offsets are word indices on the plain register port
package ssfc_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] OFF_HANDSHAKE_CONFIG = 4'h0;
   localparam logic [3:0] OFF_LINE_END_FIRST = 4'h1;
   localparam logic [3:0] OFF_LINE_END_SECOND = 4'h2;
   localparam logic [3:0] OFF_READY_CHAR = 4'h3;
   localparam logic [3:0] OFF_NOT_READY_CHAR = 4'h4;
   localparam logic [3:0] OFF_REQUEST_CHAR = 4'h5;
   localparam logic [3:0] OFF_ANSWER_CHAR = 4'h6;
   localparam logic [3:0] OFF_TX_BLOCK_SIZE = 4'h7;
   localparam logic [3:0] OFF_PROMPT_CHAR = 4'h8;
   localparam logic [3:0] OFF_RX_RESERVE_SIZE = 4'h9;
   localparam logic [3:0] OFF_STATUS = 4'hA;

   // ----------------------------------------------------------------
   // Handshake config field positions
   // ----------------------------------------------------------------
   localparam int CFG_PROMPT_LSB = 0;
   localparam int CFG_BLOCK_EN_BIT = 2;
   localparam int CFG_READY_EN_BIT = 3;
   localparam int CFG_HOST_BIT = 4;
   localparam logic [1:0] PROMPT_NONE = 2'h0;
   localparam logic [1:0] PROMPT_DETECT = 2'h1;

   // Status field positions
   localparam int ST_EMPTY_LSB = 0;
   localparam int ST_HOLD_BIT = 8;
   localparam int ST_WAIT_ANSWER_BIT = 9;
   localparam int ST_NOT_READY_SENT_BIT = 10;
   localparam int ST_LINE_OPEN_BIT = 11;
   localparam int ST_NEED_REQUEST_BIT = 12;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [4:0] RST_HANDSHAKE_CONFIG = 5'h00;
   localparam logic [7:0] RST_LINE_END_FIRST = 8'h0D;
   localparam logic [7:0] RST_LINE_END_SECOND = 8'h0A;
   localparam logic [7:0] RST_READY_CHAR = 8'h11;
   localparam logic [7:0] RST_NOT_READY_CHAR = 8'h13;
   localparam logic [7:0] RST_REQUEST_CHAR = 8'h05;
   localparam logic [7:0] RST_ANSWER_CHAR = 8'h06;
   localparam logic [7:0] RST_TX_BLOCK_SIZE = 8'h50;
   localparam logic [7:0] RST_PROMPT_CHAR = 8'h11;
   localparam logic [7:0] RST_RX_RESERVE_SIZE = 8'h0C;

   // Receive buffer size in bytes
   localparam int RX_DEPTH = 109;

   // Handshake configuration carried as one group
   typedef struct packed {
      logic host;
      logic ready_en;
      logic block_en;
      logic [1:0] prompt;
   } ssfc_cfg_type;

endpackage

// [ssfc_rx_buffer.sv]
// Purpose: Receive buffer with a count of empty bytes
// Assumes: One clock, asynchronous reset copy from the top
// Notes: A push into a full buffer is dropped
`timescale 1ns/1ps
module ssfc_rx_buffer #(
   parameter int DEPTH = ssfc_pkg::RX_DEPTH,
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready,
   output logic [7:0] empty_count
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_reg;
   logic [AW-1:0] rptr_reg;
   logic [CW-1:0] count_reg;
   wire do_push = push && (count_reg != CW'(DEPTH));
   wire do_pop = out_valid && out_ready;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   assign out_valid = (count_reg != '0);
   assign out_data = mem[rptr_reg];
   assign empty_count = 8'(CW'(DEPTH) - count_reg);

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wptr_reg] <= push_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (do_push) wptr_reg <= bump(wptr_reg);
         if (do_pop) rptr_reg <= bump(rptr_reg);
         count_reg <= count_reg + CW'(do_push) - CW'(do_pop);
      end
   end

   property p_count_bound;
      @(posedge clk) disable iff (!rst_n)
      count_reg <= CW'(DEPTH);
   endproperty
   a_count_bound: assert property (p_count_bound)
      else $error("receive buffer count above depth");
endmodule

// [ssfc_core.sv]
// Purpose: Block and ready/not-ready software flow control on a serial port
// Assumes: Character streams come from logic on ref_clk; no frame format
// Notes: Handshake characters are matched and consumed, never buffered
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

// Summary of operation
// - Writing handshake config releases every transmit hold at once, except a peer not-ready arriving in that same cycle.
// - As host, send block, then request char, then wait for answer.
// - No request character is ever caused by reset or startup.
// - As host, a prompt is never generated, only passed as data.
// - Terminal with prompt 01 halts after end-of-line, then waits for prompt; a config write opens the line.
// - Terminal with prompt 00 sends freely and ignores end-of-line.
// - Terminal answers a request only when empty bytes reach block size.
// - Receive buffer holds 109 bytes; decisions use its empty count.
// - Transmit block size register; zero code means 256.
// - Request and answer codes come from their own registers.
// - Config bit 3 enables ready/not-ready using their registers.
// - Send not-ready when empty bytes fall to reserved size.
// - Send ready after not-ready once buffer is empty; never at reset.
// - After not-ready arrives, transmission stops within three characters.
// - Reserved receive block size held in its own register.
// - Suspended data resumes with the next character, none lost.
// - Bits 3 and 2 both set run both protocols together.
module ssfc_core (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   output logic ser_tx_valid,
   output logic [7:0] ser_tx_data,
   input wire logic ser_tx_ready,
   input wire logic ser_rx_valid,
   input wire logic [7:0] ser_rx_data,
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic rx_ready
);
   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_n_reg;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   ssfc_pkg::ssfc_cfg_type cfg_reg;
   logic [7:0] eol_first_reg;
   logic [7:0] eol_second_reg;
   logic [7:0] ready_char_reg;
   logic [7:0] not_ready_char_reg;
   logic [7:0] request_char_reg;
   logic [7:0] answer_char_reg;
   logic [7:0] tx_block_size_reg;
   logic [7:0] prompt_char_reg;
   logic [7:0] rx_reserve_size_reg;
   logic [15:0] rdata_reg;

   wire wr_cfg = reg_write && reg_addr == ssfc_pkg::OFF_HANDSHAKE_CONFIG;

   function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] o);
      wr_hit = a == o;
   endfunction

   always_ff @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         cfg_reg <= ssfc_pkg::RST_HANDSHAKE_CONFIG;
         eol_first_reg <= ssfc_pkg::RST_LINE_END_FIRST;
         eol_second_reg <= ssfc_pkg::RST_LINE_END_SECOND;
         ready_char_reg <= ssfc_pkg::RST_READY_CHAR;
         not_ready_char_reg <= ssfc_pkg::RST_NOT_READY_CHAR;
         request_char_reg <= ssfc_pkg::RST_REQUEST_CHAR;
         answer_char_reg <= ssfc_pkg::RST_ANSWER_CHAR;
         tx_block_size_reg <= ssfc_pkg::RST_TX_BLOCK_SIZE;
         prompt_char_reg <= ssfc_pkg::RST_PROMPT_CHAR;
         rx_reserve_size_reg <= ssfc_pkg::RST_RX_RESERVE_SIZE;
      end else if (reg_write) begin
         if (wr_cfg) cfg_reg <= reg_wdata[4:0];
         if (wr_hit(reg_addr, ssfc_pkg::OFF_LINE_END_FIRST))
            eol_first_reg <= reg_wdata[7:0];
         if (wr_hit(reg_addr, ssfc_pkg::OFF_LINE_END_SECOND))
            eol_second_reg <= reg_wdata[7:0];
         if (wr_hit(reg_addr, ssfc_pkg::OFF_READY_CHAR))
            ready_char_reg <= reg_wdata[7:0];
         if (wr_hit(reg_addr, ssfc_pkg::OFF_NOT_READY_CHAR))
            not_ready_char_reg <= reg_wdata[7:0];
         if (wr_hit(reg_addr, ssfc_pkg::OFF_REQUEST_CHAR))
            request_char_reg <= reg_wdata[7:0];
         if (wr_hit(reg_addr, ssfc_pkg::OFF_ANSWER_CHAR))
            answer_char_reg <= reg_wdata[7:0];
         if (wr_hit(reg_addr, ssfc_pkg::OFF_TX_BLOCK_SIZE))
            tx_block_size_reg <= reg_wdata[7:0];
         if (wr_hit(reg_addr, ssfc_pkg::OFF_PROMPT_CHAR))
            prompt_char_reg <= reg_wdata[7:0];
         if (wr_hit(reg_addr, ssfc_pkg::OFF_RX_RESERVE_SIZE))
            rx_reserve_size_reg <= reg_wdata[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Receive path
   // ----------------------------------------------------------------
   logic [7:0] empty_cnt;
   wire rnr_on = cfg_reg.ready_en;
   wire blk_on = cfg_reg.block_en;
   wire is_host = blk_on && cfg_reg.host;
   wire is_term = blk_on && !cfg_reg.host;
   wire prompt_on = is_term && cfg_reg.prompt == ssfc_pkg::PROMPT_DETECT;
   wire rx_nr = ser_rx_valid && rnr_on && ser_rx_data == not_ready_char_reg;
   wire rx_rdy = ser_rx_valid && rnr_on && ser_rx_data == ready_char_reg;
   wire rx_ans = ser_rx_valid && is_host && ser_rx_data == answer_char_reg;
   wire rx_req = ser_rx_valid && is_term && ser_rx_data == request_char_reg;
   wire rx_prm = ser_rx_valid && prompt_on && ser_rx_data == prompt_char_reg;
   wire rx_ctl = rx_nr || rx_rdy || rx_ans || rx_req || rx_prm;
   wire rx_push = ser_rx_valid && !rx_ctl;

   ssfc_rx_buffer #(
      .DEPTH(ssfc_pkg::RX_DEPTH),
      .WIDTH(8)
   ) u_rx_buffer (
      .clk(ref_clk),
      .rst_n(rst_n_reg),
      .push(rx_push),
      .push_data(ser_rx_data),
      .out_valid(rx_valid),
      .out_data(rx_data),
      .out_ready(rx_ready),
      .empty_count(empty_cnt)
   );

   // ----------------------------------------------------------------
   // Transmit control
   // ----------------------------------------------------------------
   logic hold_reg;
   logic wait_answer_reg;
   logic need_request_reg;
   logic answer_pending_reg;
   logic line_open_reg;
   logic not_ready_sent_reg;
   logic [8:0] sent_cnt_reg;
   logic [7:0] prev_char_reg;
   logic out_valid_reg;
   logic [7:0] out_data_reg;

   function automatic logic [8:0] blk_len(input logic [7:0] code);
      blk_len = (code == 8'h00) ? 9'h100 : {1'b0, code};
   endfunction

   wire [8:0] blk = blk_len(tx_block_size_reg);
   wire slot = !out_valid_reg || ser_tx_ready;
   wire full_empty = empty_cnt == 8'(ssfc_pkg::RX_DEPTH);
   wire send_nr = rnr_on && !not_ready_sent_reg
      && {1'b0, empty_cnt} <= {1'b0, rx_reserve_size_reg};
   wire send_rdy = rnr_on && not_ready_sent_reg && full_empty;
   wire send_ans = is_term && answer_pending_reg
      && {1'b0, empty_cnt} >= blk;
   wire send_req = is_host && need_request_reg;
   wire ctl_any = send_nr || send_rdy || send_ans || send_req;
   wire data_ok = !(rnr_on && hold_reg)
      && !(is_host && (wait_answer_reg || need_request_reg))
      && !(prompt_on && !line_open_reg);
   wire ctl_fire = slot && ctl_any;
   wire data_fire = slot && !ctl_any && data_ok && tx_valid;
   wire [7:0] ctl_char = send_nr ? not_ready_char_reg :
      send_rdy ? ready_char_reg :
      send_ans ? answer_char_reg : request_char_reg;
   wire block_done = is_host && (sent_cnt_reg + 9'h001 == blk);
   wire eol_hit = (eol_second_reg == 8'h00) ? tx_data == eol_first_reg :
      (tx_data == eol_second_reg && prev_char_reg == eol_first_reg);

   // Upstream is popped only when a character is loaded, so a stop
   // leaves the next character waiting at the source
   assign tx_ready = data_fire;
   assign ser_tx_valid = out_valid_reg;
   assign ser_tx_data = out_data_reg;

   always_ff @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         out_valid_reg <= 1'b0;
         out_data_reg <= 8'h00;
         prev_char_reg <= 8'h00;
      end else if (slot) begin
         out_valid_reg <= ctl_fire || data_fire;
         out_data_reg <= ctl_fire ? ctl_char : tx_data;
         if (data_fire) prev_char_reg <= tx_data;
      end
   end

   // Peer not-ready hold; an arrival beats a clear in the same cycle
   always_ff @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         hold_reg <= 1'b0;
      end else if (rx_nr) begin
         hold_reg <= 1'b1;
      end else if (rx_rdy || wr_cfg) begin
         hold_reg <= 1'b0;
      end
   end

   // Host block sequencing
   always_ff @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         sent_cnt_reg <= 9'h000;
         need_request_reg <= 1'b0;
         wait_answer_reg <= 1'b0;
      end else if (wr_cfg) begin
         sent_cnt_reg <= 9'h000;
         need_request_reg <= 1'b0;
         wait_answer_reg <= 1'b0;
      end else begin
         if (data_fire && is_host) begin
            sent_cnt_reg <= block_done ? 9'h000 : sent_cnt_reg + 9'h001;
         end
         if (data_fire && block_done) begin
            need_request_reg <= 1'b1;
         end else if (ctl_fire && !send_nr && !send_rdy && !send_ans) begin
            need_request_reg <= 1'b0;
         end
         if (ctl_fire && !send_nr && !send_rdy && !send_ans && send_req) begin
            wait_answer_reg <= 1'b1;
         end else if (rx_ans) begin
            wait_answer_reg <= 1'b0;
         end
      end
   end

   // Terminal answer and prompt line gating
   always_ff @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         answer_pending_reg <= 1'b0;
         line_open_reg <= 1'b0;
      end else begin
         if (rx_req) begin
            answer_pending_reg <= 1'b1;
         end else if (ctl_fire && !send_nr && !send_rdy && send_ans) begin
            answer_pending_reg <= 1'b0;
         end
         if (rx_prm || wr_cfg) begin
            line_open_reg <= 1'b1;
         end else if (data_fire && prompt_on && eol_hit) begin
            line_open_reg <= 1'b0;
         end
      end
   end

   // Own not-ready / ready emission
   always_ff @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         not_ready_sent_reg <= 1'b0;
      end else if (!rnr_on) begin
         not_ready_sent_reg <= 1'b0;
      end else if (ctl_fire && send_nr) begin
         not_ready_sent_reg <= 1'b1;
      end else if (ctl_fire && send_rdy) begin
         not_ready_sent_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Register read
   // ----------------------------------------------------------------
   logic [15:0] status_word;
   logic [15:0] rd_mux;
   always_comb begin
      status_word = 16'h0000;
      status_word[ssfc_pkg::ST_EMPTY_LSB +: 8] = empty_cnt;
      status_word[ssfc_pkg::ST_HOLD_BIT] = hold_reg;
      status_word[ssfc_pkg::ST_WAIT_ANSWER_BIT] = wait_answer_reg;
      status_word[ssfc_pkg::ST_NOT_READY_SENT_BIT] = not_ready_sent_reg;
      status_word[ssfc_pkg::ST_LINE_OPEN_BIT] = line_open_reg;
      status_word[ssfc_pkg::ST_NEED_REQUEST_BIT] = need_request_reg;
      unique case (reg_addr)
         ssfc_pkg::OFF_HANDSHAKE_CONFIG: rd_mux = {11'h000, cfg_reg};
         ssfc_pkg::OFF_LINE_END_FIRST: rd_mux = {8'h00, eol_first_reg};
         ssfc_pkg::OFF_LINE_END_SECOND: rd_mux = {8'h00, eol_second_reg};
         ssfc_pkg::OFF_READY_CHAR: rd_mux = {8'h00, ready_char_reg};
         ssfc_pkg::OFF_NOT_READY_CHAR: rd_mux = {8'h00, not_ready_char_reg};
         ssfc_pkg::OFF_REQUEST_CHAR: rd_mux = {8'h00, request_char_reg};
         ssfc_pkg::OFF_ANSWER_CHAR: rd_mux = {8'h00, answer_char_reg};
         ssfc_pkg::OFF_TX_BLOCK_SIZE: rd_mux = {8'h00, tx_block_size_reg};
         ssfc_pkg::OFF_PROMPT_CHAR: rd_mux = {8'h00, prompt_char_reg};
         ssfc_pkg::OFF_RX_RESERVE_SIZE: rd_mux = {8'h00, rx_reserve_size_reg};
         ssfc_pkg::OFF_STATUS: rd_mux = status_word;
         default: rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         rdata_reg <= 16'h0000;
      end else begin
         rdata_reg <= reg_read ? rd_mux : 16'h0000;
      end
   end
   assign reg_rdata = rdata_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_cfg_release;
      @(posedge ref_clk) disable iff (!rst_n_reg)
      wr_cfg && !rx_nr |=> !hold_reg && !wait_answer_reg && !need_request_reg;
   endproperty
   a_cfg_release: assert property (p_cfg_release)
      else $error("config write did not release transmit holds");

   property p_block_wait;
      @(posedge ref_clk) disable iff (!rst_n_reg)
      is_host && wait_answer_reg |-> !data_fire;
   endproperty
   a_block_wait: assert property (p_block_wait)
      else $error("host sent data while waiting for answer");

   property p_request_cause;
      @(posedge ref_clk) disable iff (!rst_n_reg)
      $rose(wait_answer_reg) |-> $past(need_request_reg)
         && out_data_reg == request_char_reg;
   endproperty
   a_request_cause: assert property (p_request_cause)
      else $error("request sent without a completed block");

   property p_line_halt;
      @(posedge ref_clk) disable iff (!rst_n_reg)
      data_fire && prompt_on && eol_hit && !rx_prm && !wr_cfg
         |=> !line_open_reg ##1 !data_fire || line_open_reg;
   endproperty
   a_line_halt: assert property (p_line_halt)
      else $error("terminal kept sending after end of line");

   property p_answer_room;
      @(posedge ref_clk) disable iff (!rst_n_reg)
      ctl_fire && ctl_char == answer_char_reg && send_ans
         && !send_nr && !send_rdy |-> {1'b0, empty_cnt} >= blk;
   endproperty
   a_answer_room: assert property (p_answer_room)
      else $error("answer sent without enough buffer room");

   property p_not_ready_level;
      @(posedge ref_clk) disable iff (!rst_n_reg)
      $rose(not_ready_sent_reg) |->
         $past(empty_cnt) <= $past(rx_reserve_size_reg);
   endproperty
   a_not_ready_level: assert property (p_not_ready_level)
      else $error("not-ready sent above reserved level");

   property p_ready_empty;
      @(posedge ref_clk) disable iff (!rst_n_reg)
      $fell(not_ready_sent_reg) && $past(rnr_on) |->
         $past(full_empty) && out_data_reg == ready_char_reg;
   endproperty
   a_ready_empty: assert property (p_ready_empty)
      else $error("ready sent before buffer emptied");

   property p_hold_stop;
      @(posedge ref_clk) disable iff (!rst_n_reg)
      rx_nr && !wr_cfg |=> !data_fire [*2];
   endproperty
   a_hold_stop: assert property (p_hold_stop)
      else $error("data loaded after not-ready arrived");
endmodule

// [ssfc_peer.sv]
// Purpose: Far-side serial device that records and injects characters
// Assumes: Characters move one per ref_clk cycle, no framing
// Notes: Ready can toggle each cycle to stall the sender
`timescale 1ns/1ps
module ssfc_peer (
   input wire logic ref_clk,
   input wire logic ser_tx_valid,
   input wire logic [7:0] ser_tx_data,
   output logic ser_tx_ready,
   output logic ser_rx_valid,
   output logic [7:0] ser_rx_data
);
   logic [7:0] got[$];
   bit slow = 0;
   initial begin
      ser_tx_ready = 1'b1;
      ser_rx_valid = 1'b0;
      ser_rx_data = 8'h00;
   end
   always @(posedge ref_clk) begin
      if (ser_tx_valid && ser_tx_ready) begin
         got.push_back(ser_tx_data);
      end
      ser_tx_ready <= slow ? ~ser_tx_ready : 1'b1;
   end
   // Idle line shows the inverse of the last character
   task automatic send(input logic [7:0] c);
      @(posedge ref_clk);
      ser_rx_valid <= 1'b1;
      ser_rx_data <= c;
      @(posedge ref_clk);
      ser_rx_valid <= 1'b0;
      ser_rx_data <= ~c;
   endtask
endmodule

// [ssfc_core_bench.sv]
// Purpose: Self-checking bench for the software flow control core
// Assumes: Peer model stands on the serial side
// Notes: Expected characters come from values written here
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module ssfc_core_bench;
   logic ref_clk = 0, resetn = 0, reg_write = 0, reg_read = 0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, v;
   logic tx_valid = 0, tx_ready, ser_tx_valid, ser_tx_ready, ser_rx_valid;
   logic [7:0] tx_data = 8'h00, ser_tx_data, ser_rx_data, rx_data;
   logic rx_valid, rx_ready = 0;
   int err_total = 0, n_compared = 0, i;
   logic [3:0] ra[5] = '{4'h3, 4'h7, 4'h9, 4'h0, 4'hB};
   logic [15:0] re[5] = '{16'h0011, 16'h0050, 16'h000C, 16'h0000, 16'h0000};
   ssfc_core dut_u (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .ser_tx_valid(ser_tx_valid),
      .ser_tx_data(ser_tx_data), .ser_tx_ready(ser_tx_ready),
      .ser_rx_valid(ser_rx_valid), .ser_rx_data(ser_rx_data),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready));
   ssfc_peer peer_u (.ref_clk(ref_clk), .ser_tx_valid(ser_tx_valid),
      .ser_tx_data(ser_tx_data), .ser_tx_ready(ser_tx_ready),
      .ser_rx_valid(ser_rx_valid), .ser_rx_data(ser_rx_data));
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      @(negedge ref_clk);
      d = reg_rdata;
   endtask
   task automatic put(input logic [7:0] c);
      int k;
      @(posedge ref_clk);
      tx_valid <= 1'b1;
      tx_data <= c;
      for (k = 0; k < 50; k++) begin
         @(negedge ref_clk);
         if (tx_ready === 1'b1) break;
      end
      @(posedge ref_clk);
      tx_valid <= 1'b0;
      `CHK(k < 50, 1'b1)
   endtask
   // Offers a character and expects it to be refused throughout
   task automatic hold_check(input logic [7:0] c);
      @(posedge ref_clk);
      tx_valid <= 1'b1;
      tx_data <= c;
      repeat (8) begin
         @(negedge ref_clk);
         `CHK(tx_ready, 1'b0)
      end
      @(posedge ref_clk);
      tx_valid <= 1'b0;
   endtask
   task automatic gotc(input logic [7:0] e);
      for (int k = 0; k < 20 && peer_u.got.size() == 0; k++) @(posedge ref_clk);
      `CHK(peer_u.got.pop_front(), e)
   endtask
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      give_verdict();
   end
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (10) @(posedge ref_clk);
      `CHK(peer_u.got.size(), 0)
      for (i = 0; i < 5; i++) begin
         rd(ra[i], v);
         `CHK(v, re[i])
      end
      rd(4'hA, v);
      `CHK(v[7:0], 8'h6D)
      $display("test reset values done");
      wr(4'h3, 16'h0021);
      wr(4'h4, 16'h0023);
      wr(4'h9, 16'h0069);
      wr(4'h0, 16'h0008);
      for (i = 0; i < 4; i++) begin
         peer_u.send(8'h60 + i);
         repeat (3) @(posedge ref_clk);
         if (i == 2) `CHK(peer_u.got.size(), 0)
      end
      gotc(8'h23);
      rd(4'hA, v);
      `CHK(v[7:0], 8'h69)
      for (i = 0; i < 4; i++) begin
         @(negedge ref_clk);
         `CHK(rx_valid, 1'b1)
         `CHK(rx_data, 8'h60 + i)
         @(posedge ref_clk);
         rx_ready <= 1'b1;
         @(posedge ref_clk);
         rx_ready <= 1'b0;
      end
      gotc(8'h21);
      `CHK(rx_valid, 1'b0)
      $display("test receive buffer control done");
      for (i = 0; i < 2; i++) begin
         peer_u.send(8'h23);
         hold_check(8'h41 + i);
         if (i == 0) wr(4'h0, 16'h0008);
         else peer_u.send(8'h21);
         put(8'h41 + i);
         gotc(8'h41 + i);
      end
      $display("test peer hold done");
      wr(4'h7, 16'h0002);
      wr(4'h5, 16'h0035);
      wr(4'h6, 16'h0036);
      wr(4'h0, 16'h0014);
      peer_u.slow = 1;
      put(8'hA0);
      put(8'hA1);
      gotc(8'hA0);
      gotc(8'hA1);
      gotc(8'h35);
      hold_check(8'hA2);
      peer_u.send(8'h36);
      put(8'hA2);
      gotc(8'hA2);
      `CHK(peer_u.got.size(), 0)
      peer_u.slow = 0;
      $display("test host block done");
      wr(4'h0, 16'h0005);
      put(8'h42);
      put(8'h0D);
      put(8'h0A);
      hold_check(8'h43);
      peer_u.send(8'h11);
      put(8'h43);
      // Single-character end of line closes the line as well
      wr(4'h2, 16'h0000);
      put(8'h0D);
      hold_check(8'h45);
      // Terminal without prompt, ready/not-ready on as well
      wr(4'h0, 16'h000C);
      put(8'h0D);
      put(8'h0A);
      put(8'h44);
      repeat (4) @(posedge ref_clk);
      peer_u.got.delete();
      peer_u.send(8'h35);
      gotc(8'h36);
      $display("test terminal done");
      give_verdict();
   end
endmodule
